// File: src/rfs_regs.sv
// Fault thresholds, responses, sequencing timers and summary status of the regulator.
`timescale 1ns/1ps
module rfs_regs #(
  parameter int MS_CYCLES = rfs_pkg::MS_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Command port from the bus engine.
  input wire logic cmd_valid,
  input wire rfs_pkg::rfs_cmd_t cmd,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic rsp_err,
  // Measurements and fault inputs, same clock.
  input wire rfs_pkg::rfs_meas_t meas,
  input wire logic busy_in,
  input wire logic vout_ov_in,
  input wire logic vin_uv_in,
  input wire logic cml_in,
  // Control pin, asynchronous.
  input wire logic control_pin,
  // Power stage control and status.
  output logic power_enable,
  output logic [7:0] vcmd_frac,
  output logic pgood,
  output logic oc_warn,
  output logic ot_warn,
  output logic vin_uv_warn,
  output logic [7:0] status_byte
);

  localparam int STEP_CYCLES = MS_CYCLES / rfs_pkg::RAMP_STEPS;

  typedef enum logic [2:0] {S_OFF, S_ON_DLY, S_RISE, S_ON, S_OFF_DLY, S_FALL} rfs_state_t;

  // Slot of a command code, or NREG when the code has no storage.
  function automatic logic [4:0] slot_of(input logic [7:0] code);
    slot_of = 5'(rfs_pkg::NREG);
    for (int i = 0; i < rfs_pkg::NREG; i++)
    begin
      if (rfs_pkg::REG_CODES[i*8 +: 8] == code)
      begin
        slot_of = 5'(i);
      end
    end
  endfunction : slot_of

  // Output threshold in tenths of a millivolt at the sense pin, scaled by the loop factor.
  function automatic logic [31:0] sense_thr(input logic [15:0] raw, input logic [7:0] lsb, input logic [15:0] scale);
    logic [31:0] prod;
    prod = 32'(raw) * 32'(lsb) * 32'(scale);
    sense_thr = prod >> rfs_pkg::SCALE_FRAC_BITS;
  endfunction : sense_thr

  // Action field of an action register.
  function automatic logic [1:0] act_of(input logic [15:0] r);
    act_of = r[rfs_pkg::ACT_MSB:rfs_pkg::ACT_LSB];
  endfunction : act_of

  // Register storage.
  logic [15:0] regs_ff [rfs_pkg::NREG];
  logic [15:0] nxt_regs [rfs_pkg::NREG];
  logic rsp_valid_ff, nxt_rsp_valid;
  logic [15:0] rsp_data_ff, nxt_rsp_data;
  logic rsp_err_ff, nxt_rsp_err;
  // Control pin synchroniser.
  logic pin_meta_ff, pin_sync_ff;
  // Sticky fault bits.
  logic uv_ff, oc_ff, ot_ff, otw_ff, vov_ff, tmax_ff, busy_ff, ovo_ff, vuv_ff, cml_ff;
  logic nxt_uv, nxt_oc, nxt_ot, nxt_otw, nxt_vov, nxt_tmax, nxt_busy, nxt_ovo, nxt_vuv, nxt_cml;
  logic shut_ff, nxt_shut;
  // Sequencer.
  rfs_state_t state_ff, nxt_state;
  logic [31:0] tick_ff, nxt_tick;
  logic [15:0] ms_ff, nxt_ms;
  logic [15:0] tmax_cnt_ff, nxt_tmax_cnt;
  logic reached_ff, nxt_reached;
  logic [31:0] step_ff, nxt_step;
  logic [7:0] frac_ff, nxt_frac;
  logic pg_ff, nxt_pg;
  logic ocw_ff, otwo_ff, vuvw_ff;

  // Decoded command.
  logic [4:0] slot;
  logic wr, rd, clr, bad;
  // Live conditions.
  logic [31:0] vs10, uv_thr, pg_on_thr, pg_off_thr;
  logic uv_c, oc_c, ocw_c, ot_c, otw_c, vov_c, vuvw_c, tmax_c;
  logic run_req, inhibit, blocked, ms_tick, step_tick;
  logic [15:0] ramp_ms;

  // Command decode; the clear-faults send byte carries no data.
  always_comb
  begin
    slot = slot_of(cmd.code);
    clr = cmd_valid && cmd.write && cmd.code == rfs_pkg::CMD_CLEAR_FAULTS;
    wr = cmd_valid && cmd.write && slot != 5'(rfs_pkg::NREG);
    rd = cmd_valid && !cmd.write;
    bad = cmd_valid && slot == 5'(rfs_pkg::NREG) && !clr && !(rd && cmd.code == rfs_pkg::CMD_SUMMARY_STATUS);
  end

  // Register writes and read answers; byte commands keep only the low byte.
  always_comb
  begin
    for (int i = 0; i < rfs_pkg::NREG; i++)
    begin
      nxt_regs[i] = regs_ff[i];
      if (wr && slot == 5'(i))
      begin
        nxt_regs[i] = rfs_pkg::REG_IS_BYTE[i] ? {8'h00, cmd.wdata[7:0]} : cmd.wdata;
      end
    end
    nxt_rsp_valid = cmd_valid;
    nxt_rsp_err = bad;
    nxt_rsp_data = 16'h0000;
    if (rd && cmd.code == rfs_pkg::CMD_SUMMARY_STATUS)
    begin
      nxt_rsp_data = {8'h00, status_byte};
    end
    else if (rd && slot != 5'(rfs_pkg::NREG))
    begin
      nxt_rsp_data = regs_ff[slot];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < rfs_pkg::NREG; i++)
      begin
        regs_ff[i] <= rfs_pkg::REG_RESETS[i*16 +: 16];
      end
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 16'h0000;
      rsp_err_ff <= 1'b0;
    end
    else
    begin
      regs_ff <= nxt_regs;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff <= nxt_rsp_data;
      rsp_err_ff <= nxt_rsp_err;
    end
  end

  // The pin is asynchronous; only the second stage is read.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end
    else
    begin
      pin_meta_ff <= control_pin;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Threshold comparisons; output thresholds are moved to the sense pin by the loop scale.
  always_comb
  begin
    vs10 = 32'(meas.vsense_mv) * 32'd10;
    uv_thr = sense_thr(regs_ff[rfs_pkg::IX_UV_THR], rfs_pkg::UV_TENTH_MV, regs_ff[rfs_pkg::IX_SCALE]);
    pg_on_thr = sense_thr(regs_ff[rfs_pkg::IX_PG_ON], rfs_pkg::PG_TENTH_MV, regs_ff[rfs_pkg::IX_SCALE]);
    pg_off_thr = sense_thr(regs_ff[rfs_pkg::IX_PG_OFF], rfs_pkg::PG_TENTH_MV, regs_ff[rfs_pkg::IX_SCALE]);
    // Undervoltage is only meaningful once the output is in regulation.
    uv_c = state_ff == S_ON && vs10 < uv_thr;
    oc_c = meas.iout_half_a > regs_ff[rfs_pkg::IX_OC_THR];
    ocw_c = meas.iout_half_a > regs_ff[rfs_pkg::IX_OCW_THR];
    ot_c = meas.temp_c >= regs_ff[rfs_pkg::IX_OT_THR];
    otw_c = meas.temp_c >= regs_ff[rfs_pkg::IX_OTW_THR];
    vov_c = meas.vin_qv > regs_ff[rfs_pkg::IX_VOV_THR];
    vuvw_c = meas.vin_qv < 16'(regs_ff[rfs_pkg::IX_VUVW_THR] << 1);
    tmax_c = (state_ff == S_RISE || state_ff == S_ON) && !reached_ff && regs_ff[rfs_pkg::IX_TMAX] != 16'h0000
      && tmax_cnt_ff >= regs_ff[rfs_pkg::IX_TMAX];
  end

  // Sticky fault bits: a live condition always wins over a clear.
  always_comb
  begin
    nxt_uv = uv_c || (uv_ff && !clr);
    nxt_oc = oc_c || (oc_ff && !clr);
    nxt_ot = ot_c || (ot_ff && !clr);
    nxt_otw = otw_c || (otw_ff && !clr);
    nxt_vov = vov_c || (vov_ff && !clr);
    nxt_tmax = tmax_c || (tmax_ff && !clr);
    nxt_busy = busy_in || (busy_ff && !clr);
    nxt_ovo = vout_ov_in || (ovo_ff && !clr);
    nxt_vuv = vin_uv_in || (vuv_ff && !clr);
    nxt_cml = cml_in || bad || (cml_ff && !clr);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      uv_ff <= 1'b0;
      oc_ff <= 1'b0;
      ot_ff <= 1'b0;
      otw_ff <= 1'b0;
      vov_ff <= 1'b0;
      tmax_ff <= 1'b0;
      busy_ff <= 1'b0;
      ovo_ff <= 1'b0;
      vuv_ff <= 1'b0;
      cml_ff <= 1'b0;
      ocw_ff <= 1'b0;
      otwo_ff <= 1'b0;
      vuvw_ff <= 1'b0;
    end
    else
    begin
      uv_ff <= nxt_uv;
      oc_ff <= nxt_oc;
      ot_ff <= nxt_ot;
      otw_ff <= nxt_otw;
      vov_ff <= nxt_vov;
      tmax_ff <= nxt_tmax;
      busy_ff <= nxt_busy;
      ovo_ff <= nxt_ovo;
      vuv_ff <= nxt_vuv;
      cml_ff <= nxt_cml;
      ocw_ff <= ocw_c;
      otwo_ff <= otw_c;
      vuvw_ff <= vuvw_c;
    end
  end

  // Start request and fault responses. Shutdown latches until faults are cleared or the unit is
  // commanded off; inhibit only holds the output off while the temperature stays high.
  always_comb
  begin
    run_req = !regs_ff[rfs_pkg::IX_ONOFF][rfs_pkg::ONOFF_PU]
      || ((!regs_ff[rfs_pkg::IX_ONOFF][rfs_pkg::ONOFF_CMD] || regs_ff[rfs_pkg::IX_OPER][rfs_pkg::OPER_ON])
      && (!regs_ff[rfs_pkg::IX_ONOFF][rfs_pkg::ONOFF_PIN]
      || pin_sync_ff == regs_ff[rfs_pkg::IX_ONOFF][rfs_pkg::ONOFF_POL]));
    inhibit = ot_c && act_of(regs_ff[rfs_pkg::IX_OT_ACT]) == rfs_pkg::ACT_INHIBIT;
    nxt_shut = (uv_c && act_of(regs_ff[rfs_pkg::IX_UV_ACT]) == rfs_pkg::ACT_SHUTDOWN)
      || (oc_c && act_of(regs_ff[rfs_pkg::IX_OC_ACT]) == rfs_pkg::ACT_SHUTDOWN)
      || (ot_c && act_of(regs_ff[rfs_pkg::IX_OT_ACT]) == rfs_pkg::ACT_SHUTDOWN)
      || (vov_c && act_of(regs_ff[rfs_pkg::IX_VOV_ACT]) == rfs_pkg::ACT_SHUTDOWN)
      || (tmax_c && act_of(regs_ff[rfs_pkg::IX_TMAX_ACT]) == rfs_pkg::ACT_SHUTDOWN)
      || (shut_ff && !clr && run_req);
    blocked = shut_ff || inhibit;
  end

  // Sequencer timing: the millisecond prescaler restarts on every state change so each delay
  // is a whole number of milliseconds from its start.
  always_comb
  begin
    ms_tick = tick_ff >= 32'(MS_CYCLES - 1);
    ramp_ms = (state_ff == S_FALL) ? regs_ff[rfs_pkg::IX_TURN_OFF_FALL_TIME] : regs_ff[rfs_pkg::IX_TURN_ON_RISE_TIME];
    step_tick = step_ff + 32'd1 >= 32'(ramp_ms) * 32'(STEP_CYCLES);
    nxt_state = state_ff;
    nxt_frac = frac_ff;
    nxt_step = step_tick ? 32'd0 : step_ff + 32'd1;
    case (state_ff)
      S_OFF:
      begin
        nxt_frac = 8'h00;
        if (run_req && !blocked)
        begin
          nxt_state = S_ON_DLY;
        end
      end
      S_ON_DLY:
      begin
        if (!run_req || blocked)
        begin
          nxt_state = S_OFF;
        end
        else if (ms_ff >= regs_ff[rfs_pkg::IX_TON_DLY])
        begin
          nxt_state = S_RISE;
        end
      end
      S_RISE:
      begin
        if (ramp_ms == 16'h0000)
        begin
          nxt_frac = 8'hff;
        end
        else if (step_tick)
        begin
          nxt_frac = frac_ff + 8'h01;
        end
        if (blocked)
        begin
          nxt_state = S_OFF;
        end
        else if (!run_req)
        begin
          nxt_state = S_OFF_DLY;
        end
        else if (nxt_frac == 8'hff)
        begin
          nxt_state = S_ON;
        end
      end
      S_ON:
      begin
        if (blocked)
        begin
          nxt_state = S_OFF;
        end
        else if (!run_req)
        begin
          nxt_state = S_OFF_DLY;
        end
      end
      S_OFF_DLY:
      begin
        // Energy keeps flowing here; a fault still cuts it at once.
        if (blocked)
        begin
          nxt_state = S_OFF;
        end
        else if (ms_ff >= regs_ff[rfs_pkg::IX_TOFF_DLY])
        begin
          nxt_state = S_FALL;
        end
      end
      S_FALL:
      begin
        if (ramp_ms == 16'h0000 || frac_ff == 8'h00)
        begin
          nxt_frac = 8'h00;
        end
        else if (step_tick)
        begin
          nxt_frac = frac_ff - 8'h01;
        end
        if (blocked || nxt_frac == 8'h00)
        begin
          nxt_state = S_OFF;
        end
      end
      default:
      begin
        nxt_state = S_OFF;
      end
    endcase
    if (nxt_state == S_OFF)
    begin
      nxt_frac = 8'h00;
    end
    nxt_tick = (nxt_state != state_ff || ms_tick) ? 32'd0 : tick_ff + 32'd1;
    nxt_ms = (nxt_state != state_ff) ? 16'h0000 : (ms_tick ? ms_ff + 16'h0001 : ms_ff);
    if (nxt_state != state_ff)
    begin
      nxt_step = 32'd0;
    end
    // Power-up timer runs from the start of the rise until the undervoltage limit is reached.
    nxt_reached = (state_ff == S_RISE || state_ff == S_ON) && (reached_ff || vs10 >= uv_thr);
    nxt_tmax_cnt = (state_ff == S_RISE || state_ff == S_ON) ? ((ms_tick && !reached_ff && tmax_cnt_ff != 16'hffff)
      ? tmax_cnt_ff + 16'h0001 : tmax_cnt_ff) : 16'h0000;
    // Power good with hysteresis between the two levels.
    if (nxt_state == S_OFF || vs10 <= pg_off_thr)
    begin
      nxt_pg = 1'b0;
    end
    else if (vs10 >= pg_on_thr)
    begin
      nxt_pg = 1'b1;
    end
    else
    begin
      nxt_pg = pg_ff;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= S_OFF;
      tick_ff <= 32'd0;
      ms_ff <= 16'h0000;
      tmax_cnt_ff <= 16'h0000;
      reached_ff <= 1'b0;
      step_ff <= 32'd0;
      frac_ff <= 8'h00;
      pg_ff <= 1'b0;
      shut_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      tick_ff <= nxt_tick;
      ms_ff <= nxt_ms;
      tmax_cnt_ff <= nxt_tmax_cnt;
      reached_ff <= nxt_reached;
      step_ff <= nxt_step;
      frac_ff <= nxt_frac;
      pg_ff <= nxt_pg;
      shut_ff <= nxt_shut;
    end
  end

  // Outputs; status bit 6 is live, the rest are the sticky bits.
  assign status_byte = {busy_ff, state_ff == S_OFF, ovo_ff, oc_ff, vuv_ff, ot_ff || otw_ff, cml_ff,
    uv_ff || vov_ff || tmax_ff};
  assign power_enable = state_ff == S_RISE || state_ff == S_ON || state_ff == S_OFF_DLY || state_ff == S_FALL;
  assign vcmd_frac = frac_ff;
  assign pgood = pg_ff;
  assign oc_warn = ocw_ff;
  assign ot_warn = otwo_ff;
  assign vin_uv_warn = vuvw_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign rsp_err = rsp_err_ff;

endmodule : rfs_regs

// File: src/rfs_pkg.sv
// Constants, command codes, reset values and carrier types for the fault and sequencing register bank.
package rfs_pkg;

  // Command codes as seen on the management bus.
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CFG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_SCALE_LOOP = 8'h29;
  localparam logic [7:0] CMD_SUMMARY_STATUS = 8'h78;

  // Storage slots; code and reset value per slot, in slot order.
  localparam int NREG = 22;
  localparam int IX_OPER = 0;
  localparam int IX_ONOFF = 1;
  localparam int IX_SCALE = 2;
  localparam int IX_UV_THR = 3;
  localparam int IX_UV_ACT = 4;
  localparam int IX_OC_THR = 5;
  localparam int IX_OC_ACT = 6;
  localparam int IX_OCW_THR = 7;
  localparam int IX_OT_THR = 8;
  localparam int IX_OT_ACT = 9;
  localparam int IX_OTW_THR = 10;
  localparam int IX_VOV_THR = 11;
  localparam int IX_VOV_ACT = 12;
  localparam int IX_VUVW_THR = 13;
  localparam int IX_PG_ON = 14;
  localparam int IX_PG_OFF = 15;
  localparam int IX_TON_DLY = 16;
  localparam int IX_TURN_ON_RISE_TIME = 17;
  localparam int IX_TMAX = 18;
  localparam int IX_TMAX_ACT = 19;
  localparam int IX_TOFF_DLY = 20;
  localparam int IX_TURN_OFF_FALL_TIME = 21;
  localparam logic [NREG*8-1:0] REG_CODES = {8'h65, 8'h64, 8'h63, 8'h62, 8'h61, 8'h60, 8'h5f, 8'h5e, 8'h58, 8'h56,
    8'h55, 8'h51, 8'h50, 8'h4f, 8'h4a, 8'h47, 8'h46, 8'h45, 8'h44, CMD_SCALE_LOOP, CMD_ON_OFF_CFG, CMD_OPERATION};

  // Fault actions in bits 7:6 of every action register.
  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] ACT_SHUTDOWN = 2'h2;
  localparam logic [1:0] ACT_INHIBIT = 2'h3;
  localparam int ACT_MSB = 7;
  localparam int ACT_LSB = 6;

  // Reset values: UV 101 x 3.9mV, OC 64 x 0.5A, temperatures in 1C, VIN 96 x 0.25V, power good in 10mV, times in ms.
  localparam logic [NREG*16-1:0] REG_RESETS = {16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000,
    16'h002a, 16'h002d, 16'h0001, 16'h0080, 16'h0060, 16'h007d, 16'h00c0, 16'h0091, 16'h0038, 16'h0080,
    16'h0040, 16'h0000, 16'h0065, 16'h0100, 16'h0016, 16'h0080};
  localparam logic [NREG-1:0] REG_IS_BYTE = 22'h081253;

  // Configuration and operation bits.
  localparam int ONOFF_PU = 4;
  localparam int ONOFF_CMD = 3;
  localparam int ONOFF_PIN = 2;
  localparam int ONOFF_POL = 1;
  localparam int OPER_ON = 7;

  // Threshold scale: tenths of a millivolt per LSB, and the loop scale one-point value.
  localparam logic [7:0] UV_TENTH_MV = 8'h27;
  localparam logic [7:0] PG_TENTH_MV = 8'h64;
  localparam int SCALE_FRAC_BITS = 8;

  // Timing: one millisecond at the 50 ns clock, and one of 256 ramp steps.
  localparam int CLK_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAMP_STEPS = 256;

  // Carriers.
  typedef struct packed {
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } rfs_cmd_t;

  typedef struct packed {
    logic [15:0] vsense_mv;
    logic [15:0] iout_half_a;
    logic [15:0] temp_c;
    logic [15:0] vin_qv;
  } rfs_meas_t;

endpackage : rfs_pkg

// File: test/rfs_host_model.sv
// Management-bus host model that issues one command at a time and collects the answer.
`timescale 1ns/1ps
module rfs_host (
  // Clock.
  input wire logic mclk,
  // Command side.
  output logic cmd_valid,
  output rfs_pkg::rfs_cmd_t cmd,
  // Answer side.
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_err
);
  // The bus starts idle.
  initial
  begin
    cmd_valid = 1'b0;
    cmd = '0;
  end

  // One transfer on falling edges; the command field is inverted when released so stale data never matches.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd, output logic [15:0] rd,
    output logic err, output logic ok);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd = {wr, code, wd};
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd = ~cmd;
    ok = rsp_valid;
    rd = rsp_data;
    err = rsp_err;
  endtask : xfer
endmodule : rfs_host

// File: test/rfs_regs_chk.sv
// Concurrent checks on the ports of the fault and sequencing register bank.
`timescale 1ns/1ps
module rfs_regs_chk #(
  parameter int MS_CYCLES = 512
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Command port.
  input wire logic cmd_valid,
  input wire rfs_pkg::rfs_cmd_t cmd,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_err,
  // Measurements and fault levels.
  input wire rfs_pkg::rfs_meas_t meas,
  input wire logic busy_in,
  input wire logic vout_ov_in,
  input wire logic vin_uv_in,
  input wire logic cml_in,
  input wire logic control_pin,
  // Power stage and status.
  input wire logic power_enable,
  input wire logic [7:0] vcmd_frac,
  input wire logic pgood,
  input wire logic oc_warn,
  input wire logic ot_warn,
  input wire logic vin_uv_warn,
  input wire logic [7:0] status_byte
);
  // Everything here lives in the one clock domain.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Answer framing of the command port.
  a_rsp_follows_cmd: assert property (cmd_valid |=> rsp_valid) else $error("answer missing after command");
  a_rsp_no_spurious: assert property (!cmd_valid |=> !rsp_valid) else $error("answer without command");
  a_err_with_rsp: assert property (rsp_err |-> rsp_valid) else $error("refusal outside an answer");
  a_write_rdata_zero: assert property (cmd_valid && cmd.write |=> rsp_data == 16'h0000)
    else $error("write answer carries data");
  a_status_write_err: assert property (cmd_valid && cmd.write && cmd.code == 8'h78 |=> rsp_err)
    else $error("status write accepted");
  a_clear_read_err: assert property (cmd_valid && !cmd.write && cmd.code == 8'h03 |=> rsp_err)
    else $error("clear read accepted");

  // Fault levels reach their summary bits one cycle on and stay until cleared.
  a_busy_sets_bit: assert property (busy_in |=> status_byte[7]) else $error("busy bit not set");
  a_ov_sets_bit: assert property (vout_ov_in |=> status_byte[5]) else $error("output ov bit not set");
  a_uv_sets_bit: assert property (vin_uv_in |=> status_byte[3]) else $error("input uv bit not set");
  a_cml_sets_bit: assert property (cml_in |=> status_byte[1]) else $error("comm bit not set");
  a_busy_bit_holds: assert property (status_byte[7] && !(cmd_valid && cmd.write && cmd.code == 8'h03)
    |=> status_byte[7]) else $error("busy bit dropped without clear");
  a_clear_drops_busy: assert property (cmd_valid && cmd.write && cmd.code == 8'h03 && !busy_in
    |=> !status_byte[7]) else $error("busy bit survived clear");
  a_rise_while_on: assert property (vcmd_frac > $past(vcmd_frac) |-> power_enable)
    else $error("ramp rises with energy off");
endmodule : rfs_regs_chk

bind rfs_regs rfs_regs_chk #(.MS_CYCLES(MS_CYCLES)) u_rfs_regs_chk (.mclk(mclk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
  .meas(meas), .busy_in(busy_in), .vout_ov_in(vout_ov_in), .vin_uv_in(vin_uv_in), .cml_in(cml_in),
  .control_pin(control_pin), .power_enable(power_enable), .vcmd_frac(vcmd_frac), .pgood(pgood),
  .oc_warn(oc_warn), .ot_warn(ot_warn), .vin_uv_warn(vin_uv_warn), .status_byte(status_byte));

// File: test/rfs_regs_tb_top.sv
// Self-checking bench for the fault and sequencing register bank.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR %0t: got %h exp %h", $time, (got), (exp)); end end
module rfs_regs_tb_top;
  // A short millisecond keeps the sequencing tests brief.
  localparam int MSC = 512;
  logic mclk;
  logic rst;
  logic cmd_valid;
  rfs_pkg::rfs_cmd_t cmd;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic rsp_err;
  rfs_pkg::rfs_meas_t meas;
  logic busy_in;
  logic vout_ov_in;
  logic vin_uv_in;
  logic cml_in;
  logic control_pin;
  logic power_enable;
  logic [7:0] vcmd_frac;
  logic pgood;
  logic oc_warn;
  logic ot_warn;
  logic vin_uv_warn;
  logic [7:0] status_byte;
  logic [15:0] rd;
  logic er;
  logic ok;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  logic [7:0] rcode [19] = '{8'h44, 8'h45, 8'h46, 8'h47, 8'h4a, 8'h4f, 8'h50, 8'h51, 8'h55, 8'h56, 8'h58,
    8'h5e, 8'h5f, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65};
  logic [15:0] rval [19] = '{16'h0065, 16'h0000, 16'h0040, 16'h0080, 16'h0038, 16'h0091, 16'h00c0, 16'h007d,
    16'h0060, 16'h0080, 16'h0001, 16'h002d, 16'h002a, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0001};
  int fbit [7] = '{7, 5, 4, 3, 2, 1, 0};

  rfs_regs #(.MS_CYCLES(MSC)) u_rfs_regs (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err), .meas(meas), .busy_in(busy_in),
    .vout_ov_in(vout_ov_in), .vin_uv_in(vin_uv_in), .cml_in(cml_in), .control_pin(control_pin),
    .power_enable(power_enable), .vcmd_frac(vcmd_frac), .pgood(pgood), .oc_warn(oc_warn), .ot_warn(ot_warn),
    .vin_uv_warn(vin_uv_warn), .status_byte(status_byte));
  rfs_host u_rfs_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_err(rsp_err));

  // Clock at 20 MHz.
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Command helpers: accepted write, checked read, refused command.
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    u_rfs_host.xfer(1'b1, c, d, rd, er, ok);
    `CHK({ok, er}, 2'b10)
  endtask : wr
  task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
    u_rfs_host.xfer(1'b0, c, 16'h0000, rd, er, ok);
    `CHK({ok, er, rd}, {2'b10, exp})
  endtask : rdchk
  task automatic refused(input logic w, input logic [7:0] c);
    u_rfs_host.xfer(w, c, 16'h0000, rd, er, ok);
    `CHK({ok, er}, 2'b11)
  endtask : refused

  // Fault injection; the released values of current and input voltage sit exactly on their limits.
  task automatic set_fault(input int k, input logic on);
    case (k)
      0: busy_in = on;
      1: vout_ov_in = on;
      2: meas.iout_half_a = on ? 16'd65 : 16'd64;
      3: vin_uv_in = on;
      4: meas.temp_c = on ? 16'd145 : 16'd0;
      5: cml_in = on;
      default: meas.vin_qv = on ? 16'd97 : 16'd96;
    endcase
  endtask : set_fault

  // Bounded wait on a sequencing event, counting falling edges.
  function automatic logic cond(input int k);
    case (k)
      0: return power_enable === 1'b1;
      1: return vcmd_frac === 8'hff;
      2: return vcmd_frac !== 8'hff;
      default: return power_enable === 1'b0;
    endcase
  endfunction : cond
  task automatic wait_for(input int k);
    n = 0;
    while (!cond(k) && n < 3000)
    begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_for

  // Verdict and end of run.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // Hang guard, well above the few thousand cycles the tests need.
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc >= 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  // Test sequence.
  initial
  begin
    rst = 1'b1;
    meas = '0;
    meas.vsense_mv = 16'd600;
    {busy_in, vout_ov_in, vin_uv_in, cml_in, control_pin} = '0;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    `CHK(status_byte, 8'h40)
    for (int i = 0; i < 19; i++)
      rdchk(rcode[i], rval[i]);
    for (int i = 0; i < 19; i++)
    begin
      wr(rcode[i], {8'ha5, 8'(i)});
      rdchk(rcode[i], (rcode[i] inside {8'h45, 8'h47, 8'h50, 8'h56, 8'h63}) ? 16'(i) : {8'ha5, 8'(i)});
      wr(rcode[i], rval[i]);
    end
    $display("test registers done");
    refused(1'b0, 8'h03);
    refused(1'b1, 8'h78);
    refused(1'b0, 8'h10);
    rdchk(8'h78, 16'h0042);
    wr(8'h03, 16'h0000);
    rdchk(8'h78, 16'h0040);
    $display("test refusals done");
    // Each warning input moves from its last quiet value to its first warning value; limits of 56 half-amps and 2 quarter-volts.
    meas.temp_c = 16'd124;
    meas.iout_half_a = 16'd56;
    meas.vin_qv = 16'd2;
    repeat (3) @(negedge mclk);
    `CHK({ot_warn, oc_warn, vin_uv_warn}, 3'b000)
    meas.temp_c = 16'd125;
    meas.iout_half_a = 16'd57;
    meas.vin_qv = 16'd1;
    repeat (3) @(negedge mclk);
    `CHK({ot_warn, oc_warn, vin_uv_warn}, 3'b111)
    meas.temp_c = 16'd0;
    meas.iout_half_a = 16'd0;
    wr(8'h03, 16'h0000);
    // Each fault alone, pulsed for one cycle, must leave only its own bit behind.
    for (int k = 0; k < 7; k++)
    begin
      set_fault(k, 1'b1);
      @(negedge mclk);
      set_fault(k, 1'b0);
      repeat (2) @(negedge mclk);
      rdchk(8'h78, 16'h0040 | (16'h0001 << fbit[k]));
      wr(8'h03, 16'h0000);
      rdchk(8'h78, 16'h0040);
    end
    $display("test faults done");
    wr(8'h60, 16'h0002);
    wr(8'h64, 16'h0001);
    control_pin = 1'b1;
    wait_for(0);
    `CHK(n inside {[1024:1036]}, 1'b1)
    wait_for(1);
    `CHK(n inside {[505:520]}, 1'b1)
    repeat (4) @(negedge mclk);
    `CHK(pgood, 1'b1)
    meas.vsense_mv = 16'd400;
    repeat (4) @(negedge mclk);
    `CHK(pgood, 1'b0)
    // Halving the loop scale halves both levels at the sense pin, so the same 400mV is good again.
    wr(8'h29, 16'h0080);
    repeat (2) @(negedge mclk);
    `CHK(pgood, 1'b1)
    wr(8'h29, 16'h0100);
    meas.vsense_mv = 16'd600;
    control_pin = 1'b0;
    wait_for(2);
    `CHK(n inside {[512:530]}, 1'b1)
    wait_for(3);
    `CHK(n inside {[505:520]}, 1'b1)
    `CHK(vcmd_frac, 8'h00)
    rdchk(8'h78, 16'h0040);
    $display("test sequencing done");
    wr(8'h60, 16'h0000);
    wr(8'h45, 16'h0080);
    control_pin = 1'b1;
    wait_for(1);
    repeat (4) @(negedge mclk);
    meas.vsense_mv = 16'd300;
    repeat (3) @(negedge mclk);
    `CHK(power_enable, 1'b0)
    control_pin = 1'b0;
    meas.vsense_mv = 16'd600;
    rdchk(8'h78, 16'h0041);
    wr(8'h03, 16'h0000);
    rdchk(8'h78, 16'h0040);
    $display("test shutdown done");
    // A slow rise with the output held low runs into a one-millisecond power-up limit set to shut down.
    wr(8'h61, 16'h0004);
    wr(8'h62, 16'h0001);
    wr(8'h63, 16'h0080);
    meas.vsense_mv = 16'd300;
    control_pin = 1'b1;
    wait_for(0);
    wait_for(3);
    `CHK(n inside {[510:520]}, 1'b1)
    control_pin = 1'b0;
    meas.vsense_mv = 16'd600;
    rdchk(8'h78, 16'h0041);
    wr(8'h03, 16'h0000);
    rdchk(8'h78, 16'h0040);
    $display("test power-up timeout done");
    print_verdict();
  end
endmodule : rfs_regs_tb_top
